// [common/rcpc_pkg.sv]
// Shared constants and types for the clock configuration and power block
// Behaviour
// - Module enable accepts writes only while value write enable is one.
// - Value registers writable only while value write enable is one.
// - Read sync status is set while a rollover ripple may change values.
// - Half second status reads one in second half, zero in first.
// - Half second status is read-only; cleared by minutes/seconds low write.
// - Window pointer selects value fields; decrements per high access to 00.
// - Both configuration registers reset only by power-on reset.
// - Power control output active-high when polarity one, else active-low.
// - Stability window clock is source divided by two or by one.
// - Sample window clock is source divided by two or by one.
// - Clock select picks oscillator, low-power RC, 50 Hz or 60 Hz line.
package rcpc_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] CFG_IDX = 4'h0;
   localparam logic [3:0] PWR_IDX = 4'h1;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] PWR_RESET = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;
   localparam int N_SOURCES = 4;
   localparam logic [1:0] PTR_FLOOR = 2'h0;

   typedef enum logic [1:0] {
      RCPC_SRC_SECONDARY_OSC,
      RCPC_SRC_LOW_POWER_RC,
      RCPC_SRC_LINE_50HZ,
      RCPC_SRC_LINE_60HZ
   } rcpc_src_t;

   typedef enum logic [1:0] {
      RCPC_OUT_ALARM_PULSE,
      RCPC_OUT_SECONDS_CLOCK,
      RCPC_OUT_RESERVED,
      RCPC_OUT_POWER_CONTROL
   } rcpc_out_t;

   typedef struct packed {
      logic module_enable;
      logic unused14;
      logic value_write_enable;
      logic read_sync_status;
      logic half_second_status;
      logic clock_output_enable;
      logic [1:0] value_window_pointer;
      logic [7:0] calibration;
   } rcpc_calib_cfg_t;

   typedef struct packed {
      logic power_ctl_enable;
      logic power_ctl_polarity;
      logic stability_window_prescale;
      logic sample_window_prescale;
      rcpc_src_t timing_source_select;
      rcpc_out_t output_source_select;
      logic [7:0] unused7_0;
   } rcpc_power_cfg_t;

   typedef struct packed {
      logic data;
      logic enable;
   } rcpc_pin_t;
endpackage

// [design/rcpc_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module rcpc_sync #(
   parameter int W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   always_comb
   begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule

// [design/rcpc_div.sv]
// Divide-by-one or divide-by-two enable pulse prescaler
`timescale 1ns/1ps
module rcpc_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic div2_i,
   output logic tick_o
);
   logic phase;
   logic next_phase;
   logic next_tick;

   // Window tick divider
   always_comb
   begin
      next_phase = phase;
      next_tick = 1'b0;
      if (tick_i)
      begin
         next_phase = div2_i ? ~phase : 1'b0;
         next_tick = ~div2_i | phase;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase <= 1'b0;
         tick_o <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         tick_o <= next_tick;
      end
   end

   property p_div1;
      @(posedge clk_i) disable iff (rst_i)
      (tick_i && !div2_i) |=> tick_o;
   endproperty
   a_div1: assert property (p_div1)
      else $error("divide-by-one tick missing");

   property p_div2;
      @(posedge clk_i) disable iff (rst_i)
      (tick_i && div2_i && !phase) |=> !tick_o;
   endproperty
   a_div2: assert property (p_div2)
      else $error("divide-by-two passed an odd tick");
endmodule

// [design/rcpc_top.sv]
// Clock/calendar configuration, window pointer and power control logic
`timescale 1ns/1ps
module rcpc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [rcpc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic rollover_busy_i,
   input wire logic half_tick_i,
   input wire logic second_tick_i,
   input wire logic minutes_seconds_reg_low_wr_i,
   input wire logic value_high_access_i,
   input wire logic alarm_pulse_i,
   input wire logic seconds_clk_i,
   input wire logic pwc_request_i,
   input wire logic [rcpc_pkg::N_SOURCES-1:0] osc_pins_i,
   output logic module_enable_o,
   output logic value_write_allow_o,
   output logic [1:0] value_window_pointer_o,
   output logic [7:0] calibration_o,
   output logic source_tick_o,
   output logic stability_tick_o,
   output logic sample_tick_o,
   output logic pwc_o,
   output logic clk_out_o,
   output logic clk_out_oe_o
);
   rcpc_pkg::rcpc_calib_cfg_t cfg;
   rcpc_pkg::rcpc_calib_cfg_t next_cfg;
   rcpc_pkg::rcpc_calib_cfg_t wcfg;
   rcpc_pkg::rcpc_power_cfg_t pwr;
   rcpc_pkg::rcpc_power_cfg_t next_pwr;
   rcpc_pkg::rcpc_pin_t pin;
   rcpc_pkg::rcpc_pin_t next_pin;
   logic [15:0] next_rdata;
   logic [rcpc_pkg::N_SOURCES-1:0] src_sync;
   logic src_prev;
   logic next_src_prev;
   logic src_level;
   logic src_tick;
   logic next_src_tick;
   logic wr_cfg;
   logic wr_pwr;
   logic pwc_level;
   logic next_pwc;

   assign wcfg = rcpc_pkg::rcpc_calib_cfg_t'(wdata_i);
   assign wr_cfg = wr_i && (addr_i == rcpc_pkg::CFG_IDX);
   assign wr_pwr = wr_i && (addr_i == rcpc_pkg::PWR_IDX);

   // Oscillator and line pins are asynchronous
   rcpc_sync #(
      .W(rcpc_pkg::N_SOURCES)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(osc_pins_i),
      .sync_o(src_sync)
   );

   assign src_level = src_sync[pwr.timing_source_select];

   // Configuration register group
   always_comb
   begin
      next_cfg = cfg;
      next_pwr = pwr;
      next_cfg.read_sync_status = rollover_busy_i;
      // half second phase; set wins over the clear
      if (half_tick_i)
      begin
         next_cfg.half_second_status = 1'b1;
      end
      else if (second_tick_i || minutes_seconds_reg_low_wr_i)
      begin
         next_cfg.half_second_status = 1'b0;
      end
      if (wr_cfg)
      begin
         next_cfg.value_write_enable = wcfg.value_write_enable;
         next_cfg.clock_output_enable = wcfg.clock_output_enable;
         next_cfg.value_window_pointer = wcfg.value_window_pointer;
         next_cfg.calibration = wcfg.calibration;
         if (cfg.value_write_enable)
         begin
            next_cfg.module_enable = wcfg.module_enable;
         end
      end
      else if (value_high_access_i &&
               cfg.value_window_pointer != rcpc_pkg::PTR_FLOOR)
      begin
         next_cfg.value_window_pointer = cfg.value_window_pointer - 2'h1;
      end
      if (wr_pwr)
      begin
         next_pwr = rcpc_pkg::rcpc_power_cfg_t'(wdata_i);
         next_pwr.unused7_0 = 8'h00;
      end
      next_cfg.unused14 = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg <= rcpc_pkg::rcpc_calib_cfg_t'(rcpc_pkg::CFG_RESET);
         pwr <= rcpc_pkg::rcpc_power_cfg_t'(rcpc_pkg::PWR_RESET);
      end
      else
      begin
         cfg <= next_cfg;
         pwr <= next_pwr;
      end
   end

   // Read port group
   always_comb
   begin
      next_rdata = 16'h0000;
      if (rd_i)
      begin
         if (addr_i == rcpc_pkg::CFG_IDX)
         begin
            next_rdata = cfg;
         end
         else if (addr_i == rcpc_pkg::PWR_IDX)
         begin
            next_rdata = pwr;
         end
         else
         begin
            next_rdata = rcpc_pkg::UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 16'h0000;
      end
      else
      begin
         rdata_o <= next_rdata;
      end
   end

   assign pwc_level = pwr.power_ctl_polarity ? pwc_request_i
                                             : ~pwc_request_i;

   // Source tick and pin group
   always_comb
   begin
      next_src_prev = src_level;
      next_src_tick = src_level & ~src_prev & cfg.module_enable;
      next_pwc = pwr.power_ctl_enable ? pwc_level
                                      : ~pwr.power_ctl_polarity;
      next_pin.enable = cfg.clock_output_enable;
      unique case (pwr.output_source_select)
         rcpc_pkg::RCPC_OUT_ALARM_PULSE: next_pin.data = alarm_pulse_i;
         rcpc_pkg::RCPC_OUT_SECONDS_CLOCK: next_pin.data = seconds_clk_i;
         rcpc_pkg::RCPC_OUT_RESERVED: next_pin.data = 1'b0;
         rcpc_pkg::RCPC_OUT_POWER_CONTROL: next_pin.data = next_pwc;
      endcase
   end

   // A source change may yield one stray tick; seconds rewrite covers it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         src_prev <= 1'b0;
         src_tick <= 1'b0;
         pwc_o <= 1'b1;
         pin <= '0;
      end
      else
      begin
         src_prev <= next_src_prev;
         src_tick <= next_src_tick;
         pwc_o <= next_pwc;
         pin <= next_pin;
      end
   end

   rcpc_div u_stab (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(src_tick),
      .div2_i(pwr.stability_window_prescale),
      .tick_o(stability_tick_o)
   );

   rcpc_div u_samp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(src_tick),
      .div2_i(pwr.sample_window_prescale),
      .tick_o(sample_tick_o)
   );

   assign source_tick_o = src_tick;
   assign module_enable_o = cfg.module_enable;
   assign value_write_allow_o = cfg.value_write_enable;
   assign value_window_pointer_o = cfg.value_window_pointer;
   assign calibration_o = cfg.calibration;
   assign clk_out_o = pin.data;
   assign clk_out_oe_o = pin.enable;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_locked_cfg_write;
      wr_cfg && !cfg.value_write_enable;
   endsequence

   sequence s_open_cfg_write;
      wr_cfg && cfg.value_write_enable;
   endsequence

   property p_enable_lock;
      s_locked_cfg_write |=> $stable(cfg.module_enable);
   endproperty
   a_enable_lock: assert property (p_enable_lock)
      else $error("module enable changed while locked");

   property p_enable_write;
      s_open_cfg_write |=> module_enable_o == $past(wcfg.module_enable);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("module enable write lost");

   property p_write_allow;
      wr_cfg |=> value_write_allow_o == $past(wcfg.value_write_enable);
   endproperty
   a_write_allow: assert property (p_write_allow)
      else $error("value write gate wrong");

   property p_read_sync;
      rollover_busy_i |=> cfg.read_sync_status;
   endproperty
   a_read_sync: assert property (p_read_sync)
      else $error("read sync not raised");

   property p_half_set;
      half_tick_i |=> cfg.half_second_status;
   endproperty
   a_half_set: assert property (p_half_set)
      else $error("half second not set");

   property p_half_clear;
      (minutes_seconds_reg_low_wr_i && !half_tick_i) |=> !cfg.half_second_status;
   endproperty
   a_half_clear: assert property (p_half_clear)
      else $error("half second not cleared");

   property p_oe;
      wr_cfg |=> ##1 clk_out_oe_o == $past(wcfg.clock_output_enable, 2);
   endproperty
   a_oe: assert property (p_oe)
      else $error("output enable wrong");

   property p_ptr_step;
      (value_high_access_i && !wr_cfg && value_window_pointer_o != 2'h0)
      |=> value_window_pointer_o == $past(value_window_pointer_o) - 2'h1;
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not decrement");

   property p_ptr_floor;
      (value_high_access_i && !wr_cfg && value_window_pointer_o == 2'h0)
      |=> value_window_pointer_o == 2'h0;
   endproperty
   a_ptr_floor: assert property (p_ptr_floor)
      else $error("pointer wrapped below floor");

   property p_pwc_pol;
      (pwr.power_ctl_enable && pwc_request_i)
      |=> pwc_o == $past(pwr.power_ctl_polarity);
   endproperty
   a_pwc_pol: assert property (p_pwc_pol)
      else $error("power control polarity wrong");

   property p_pwc_off;
      !pwr.power_ctl_enable |=> pwc_o == !$past(pwr.power_ctl_polarity);
   endproperty
   a_pwc_off: assert property (p_pwc_off)
      else $error("disabled power control not idle");

   property p_tick_gate;
      source_tick_o |-> $past(cfg.module_enable);
   endproperty
   a_tick_gate: assert property (p_tick_gate)
      else $error("tick while module disabled");
endmodule

// [sim/testbench.sv]
// Self-checking testbench for the configuration and power control block
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [rcpc_pkg::ADDR_W-1:0] addr_i = '0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic rollover_busy_i = 1'b0;
   logic [3:0] pls = 4'h0;
   logic alarm_pulse_i = 1'b0;
   logic seconds_clk_i = 1'b0;
   logic pwc_request_i = 1'b0;
   logic [3:0] osc_pins_i = 4'h0;
   logic [15:0] rdata_o;
   logic module_enable_o;
   logic value_write_allow_o;
   logic [1:0] value_window_pointer_o;
   logic [7:0] calibration_o;
   logic source_tick_o;
   logic stability_tick_o;
   logic sample_tick_o;
   logic pwc_o;
   logic clk_out_o;
   logic clk_out_oe_o;
   int err_count = 0;
   int tests_run = 0;

   rcpc_top i_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .rollover_busy_i(rollover_busy_i),
      .half_tick_i(pls[0]),
      .second_tick_i(pls[1]),
      .minutes_seconds_reg_low_wr_i(pls[2]),
      .value_high_access_i(pls[3]),
      .alarm_pulse_i(alarm_pulse_i),
      .seconds_clk_i(seconds_clk_i),
      .pwc_request_i(pwc_request_i),
      .osc_pins_i(osc_pins_i),
      .module_enable_o(module_enable_o),
      .value_write_allow_o(value_write_allow_o),
      .value_window_pointer_o(value_window_pointer_o),
      .calibration_o(calibration_o),
      .source_tick_o(source_tick_o),
      .stability_tick_o(stability_tick_o),
      .sample_tick_o(sample_tick_o),
      .pwc_o(pwc_o),
      .clk_out_o(clk_out_o),
      .clk_out_oe_o(clk_out_oe_o)
   );

   always #2 clk_i = ~clk_i;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic pulse(input int k);
      @(posedge clk_i);
      pls[k] <= 1'b1;
      @(posedge clk_i);
      pls[k] <= 1'b0;
      #1;
   endtask

   task automatic t_reset();
      logic [15:0] d;
      rd(4'h0, d);
      chk(d, 16'h0000);
      rd(4'h1, d);
      chk(d, 16'h0000);
      chk(16'(pwc_o), 16'h0001);
      // Unmapped place reads zero, write dropped
      wr(4'h2, 16'hffff);
      rd(4'h2, d);
      chk(d, 16'h0000);
      $display("reset test done");
   endtask

   task automatic t_lock();
      logic [15:0] d;
      wr(4'h0, 16'h8000);
      chk(16'(module_enable_o), 16'h0000);
      wr(4'h0, 16'h2000);
      chk(16'(value_write_allow_o), 16'h0001);
      // Status and unused bits ignore writes
      wr(4'h0, 16'hfcc5);
      rd(4'h0, d);
      chk(d, 16'ha4c5);
      // Read data stands one cycle only
      @(posedge clk_i);
      #1;
      chk(rdata_o, 16'h0000);
      chk(16'(calibration_o), 16'h00c5);
      wr(4'h0, 16'h0000);
      chk(16'(value_write_allow_o), 16'h0000);
      chk(16'(module_enable_o), 16'h0000);
      wr(4'h0, 16'h8000);
      chk(16'(module_enable_o), 16'h0000);
      $display("lock test done");
   endtask

   task automatic t_status();
      logic [15:0] d;
      @(posedge clk_i);
      rollover_busy_i <= 1'b1;
      rd(4'h0, d);
      chk(d, 16'h1000);
      rollover_busy_i <= 1'b0;
      rd(4'h0, d);
      chk(d, 16'h0000);
      pulse(0);
      rd(4'h0, d);
      chk(d, 16'h0800);
      pulse(1);
      rd(4'h0, d);
      chk(d, 16'h0000);
      pulse(0);
      wr(4'h0, 16'h2000);
      rd(4'h0, d);
      chk(d, 16'h2800);
      pulse(2);
      rd(4'h0, d);
      chk(d, 16'h2000);
      $display("status test done");
   endtask

   task automatic t_pointer();
      logic [15:0] e;
      wr(4'h0, 16'h2300);
      for (int i = 0; i < 4; i++)
      begin
         pulse(3);
         e = (i < 3) ? 16'(2 - i) : 16'h0000;
         chk(16'(value_window_pointer_o), e);
      end
      $display("pointer test done");
   endtask

   task automatic t_power();
      logic e;
      for (int k = 0; k < 8; k++)
      begin
         wr(4'h1, {k[2], k[1], 14'h0000});
         pwc_request_i <= k[0];
         repeat (2) @(posedge clk_i);
         #1;
         e = k[2] ? (k[1] ? k[0] : ~k[0]) : ~k[1];
         chk(16'(pwc_o), 16'(e));
      end
      $display("power test done");
   endtask

   task automatic t_outsel();
      logic e;
      wr(4'h0, 16'h2400);
      for (int p = 0; p < 2; p++)
      begin
         alarm_pulse_i <= ~p[0];
         seconds_clk_i <= p[0];
         pwc_request_i <= ~p[0];
         for (int s = 0; s < 4; s++)
         begin
            wr(4'h1, {2'b11, 4'h0, 2'(s), 8'h00});
            repeat (3) @(posedge clk_i);
            #1;
            e = (s == 0) ? ~p[0] : (s == 1) ? p[0] : (s == 3) ? ~p[0] : 1'b0;
            chk(16'(clk_out_o), 16'(e));
            chk(16'(clk_out_oe_o), 16'h0001);
         end
      end
      wr(4'h0, 16'h2000);
      repeat (2) @(posedge clk_i);
      #1;
      chk(16'(clk_out_oe_o), 16'h0000);
      $display("output select test done");
   endtask

   // Four pin pulses per source; divide-by-two keeps half of them
   task automatic t_source(input int s, input logic en);
      int a;
      int b;
      int c;
      a = 0;
      b = 0;
      c = 0;
      wr(4'h0, en ? 16'ha000 : 16'h2000);
      wr(4'h1, {2'b00, 1'(s), 1'(s >> 1), 2'(s), 10'h000});
      repeat (6) @(posedge clk_i);
      pulse(2);
      for (int i = 0; i < 56; i++)
      begin
         @(posedge clk_i);
         osc_pins_i <= (i < 48 && (i % 12) < 6) ? 4'(1 << s) : 4'h0;
         #1;
         a += int'(source_tick_o);
         b += int'(stability_tick_o);
         c += int'(sample_tick_o);
      end
      chk(16'(a), en ? 16'h4 : 16'h0);
      chk(16'(b), !en ? 16'h0 : s[0] ? 16'h2 : 16'h4);
      chk(16'(c), !en ? 16'h0 : s[1] ? 16'h2 : 16'h4);
      $display("source test done");
   endtask

   task automatic t_reset2();
      logic [15:0] d;
      rd(4'h1, d);
      chk(d, 16'h3c00);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, d);
      chk(d, 16'h0000);
      rd(4'h1, d);
      chk(d, 16'h0000);
      $display("second reset test done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #100000;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end

   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_lock();
      t_status();
      t_pointer();
      t_power();
      t_outsel();
      t_source(0, 1'b0);
      for (int s = 0; s < 4; s++)
         t_source(s, 1'b1);
      t_reset2();
      results();
   end
endmodule
